//--- logic/flash_status_regs.vh
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH

// ==========================================================
// Controller register offsets (byte addresses, APB)
`define REG_CMD_OFS        12'h000
`define REG_ADDR_OFS       12'h004
`define REG_WDATA_OFS      12'h008
`define REG_STATUS_OFS     12'h00C
`define REG_RDATA_OFS      12'h010

// ==========================================================
// Command codes written to the command register
`define CMD_NONE           3'h0
`define CMD_WRITE          3'h1
`define CMD_READ           3'h2
`define CMD_POLL           3'h3
`define CMD_POLL_ERASE     3'h4

// ==========================================================
// Status fields read back on the flash data pins
`define BIT_DATA_POLLING   7
`define BIT_FIRST_TOGGLE   6
`define BIT_TIMEOUT_ERROR  5
`define BIT_ERASE_TIMER    3
`define BIT_SECOND_TOGGLE  2
`define BIT_BUFFER_ABORT   1

// ==========================================================
// Controller status register fields
`define ST_BUSY            0
`define ST_DONE            1
`define ST_TIMEOUT         2
`define ST_ABORT           3
`define ST_ERASE_STARTED   4
`define ST_READY_PIN       5
`define ST_SECTOR_ERASING  6

// ==========================================================
// Bus cycle timing
`define CYCLE_NS           8
`define ACCESS_NS          120
`define ACCESS_CYCLES      ((`ACCESS_NS + `CYCLE_NS - 1) / `CYCLE_NS)
`define RESET_VAL_STATUS   32'h00000000

`endif

//--- logic/flash_bus_cycle.v
`timescale 1ns/1ps
// ==========================================================
// One asynchronous flash bus cycle: read or write strobe
`include "flash_status_regs.vh"

module flash_bus_cycle (
    // Clock and reset
    input  wire        clock,
    input  wire        rst,
    // Request
    input  wire        start,
    input  wire        write,
    input  wire [22:0] addr,
    input  wire [15:0] wdata,
    output wire        done,
    output reg  [15:0] rdata,
    // Flash pins
    output reg  [22:0] flash_addr,
    output reg         flash_ce_n,
    output reg         flash_oe_n,
    output reg         flash_we_n,
    output reg  [15:0] flash_dq_out,
    output reg         flash_dq_oe,
    input  wire [15:0] flash_dq_in
);

    // Cycle count is cut to the counter width on purpose; it is far below 256
    localparam integer ACCESS_INT = `ACCESS_CYCLES;
    localparam [7:0]   ACCESS     = ACCESS_INT[7:0];

    reg  [7:0]  count;
    reg         active;
    reg  [15:0] dq_meta;
    reg  [15:0] dq_sync;
    reg         done_r;

    assign done = done_r;

    // Two-stage capture of the data pins
    always @(posedge clock) begin
        dq_meta <= flash_dq_in;
        dq_sync <= dq_meta;
    end

    // Strobe low for the access time plus two sync stages, then release
    always @(posedge clock) begin
        if (rst) begin
            count        <= 8'h00;
            active       <= 1'b0;
            done_r       <= 1'b0;
            rdata        <= 16'h0000;
            flash_addr   <= 23'h000000;
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_dq_out <= 16'h0000;
            flash_dq_oe  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start && !active) begin
                active       <= 1'b1;
                count        <= 8'h00;
                flash_addr   <= addr;
                flash_ce_n   <= 1'b0;
                flash_oe_n   <= write;
                flash_we_n   <= !write;
                flash_dq_out <= wdata;
                flash_dq_oe  <= write;
            end else if (active) begin
                count <= count + 8'h01;
                if (count == ACCESS + 8'h02) begin
                    rdata      <= dq_sync;
                    flash_ce_n <= 1'b1;
                    flash_oe_n <= 1'b1;
                    flash_we_n <= 1'b1;
                end
                // One idle cycle keeps data held past the write strobe
                if (count == ACCESS + 8'h03) begin
                    flash_dq_oe <= 1'b0;
                    active      <= 1'b0;
                    done_r      <= 1'b1;
                end
            end
        end
    end

endmodule // flash_bus_cycle

//--- logic/flash_status_host.v
`timescale 1ns/1ps
// Summary of operation
// - After timeout the host writes the reset command to return to reads.
// - Host issuing added sectors within 50 us may skip the timer check.
// - Host confirms acceptance by toggle bit before reading erase timer flag.
// - Host reads timer flag before and after each added sector erase.
// - Buffer abort flag set on aborted buffer write; host sends a plain reset, abort-reset unlock cycles are left to software.
// - Host polls status at the target address or an erasing sector.
// - Buffered program completion is polled at the last loaded address.
`include "flash_status_regs.vh"

module flash_status_host (
    // Clock and reset
    input  wire        clock,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Flash pins
    output wire [22:0] flash_addr,
    output wire        flash_ce_n,
    output wire        flash_oe_n,
    output wire        flash_we_n,
    output wire [15:0] flash_dq_out,
    output wire        flash_dq_oe,
    input  wire [15:0] flash_dq_in,
    input  wire        ready_busy_output
);

    // ==========================================================
    // State codes
    localparam [2:0] S_IDLE   = 3'h0;
    localparam [2:0] S_CYCLE  = 3'h1;
    localparam [2:0] S_FIRST  = 3'h2;
    localparam [2:0] S_SECOND = 3'h3;
    localparam [2:0] S_RECHK  = 3'h4;
    localparam [2:0] S_RESET  = 3'h5;

    reg  [2:0]  state;
    reg  [2:0]  cmd;
    reg  [22:0] addr;
    reg  [15:0] wdata;
    reg  [15:0] rdata_hold;
    reg  [15:0] prev;
    reg         busy;
    reg         done_flag;
    reg         timeout;
    reg         aborted;
    reg         erase_started;
    reg         sector_erasing;
    reg         rb_meta;
    reg         rb_sync;
    reg         cyc_start;
    reg         cyc_write;
    reg  [22:0] cyc_addr;
    reg  [15:0] cyc_wdata;
    reg         rechk_timeout;

    wire        cyc_done;
    wire [15:0] cyc_rdata;
    wire        toggling;
    wire        wr_access;

    // ==========================================================
    // APB slave: zero-wait, unmapped reads return zero with an error
    assign pready    = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign pslverr   = psel && penable && (paddr > `REG_RDATA_OFS || paddr[1:0] != 2'h0);

    // Read mux
    always @* begin
        case (paddr)
            `REG_ADDR_OFS:   prdata = {9'h000, addr};
            `REG_WDATA_OFS:  prdata = {16'h0000, wdata};
            `REG_STATUS_OFS: prdata = {25'h0000000, sector_erasing, rb_sync, erase_started,
                                       aborted, timeout, done_flag, busy};
            `REG_RDATA_OFS:  prdata = {16'h0000, rdata_hold};
            default:         prdata = 32'h00000000;
        endcase
    end

    // Ready-busy pin is asynchronous to the clock
    always @(posedge clock) begin
        rb_meta <= ready_busy_output;
        rb_sync <= rb_meta;
    end

    // First toggle bit compared across two consecutive reads
    assign toggling = (prev[`BIT_FIRST_TOGGLE] != cyc_rdata[`BIT_FIRST_TOGGLE]);

    // ==========================================================
    // Sequencer: accepts a command only while idle, ignores writes when busy
    always @(posedge clock) begin
        if (rst) begin
            state          <= S_IDLE;
            cmd            <= `CMD_NONE;
            addr           <= 23'h000000;
            wdata          <= 16'h0000;
            rdata_hold     <= 16'h0000;
            prev           <= 16'h0000;
            busy           <= 1'b0;
            done_flag      <= 1'b0;
            timeout        <= 1'b0;
            aborted        <= 1'b0;
            erase_started  <= 1'b0;
            sector_erasing <= 1'b0;
            cyc_start      <= 1'b0;
            cyc_write      <= 1'b0;
            cyc_addr       <= 23'h000000;
            cyc_wdata      <= 16'h0000;
            rechk_timeout  <= 1'b0;
        end else begin
            cyc_start <= 1'b0;
            if (wr_access && !busy) begin
                if (paddr == `REG_ADDR_OFS)
                    addr <= pwdata[22:0];
                if (paddr == `REG_WDATA_OFS)
                    wdata <= pwdata[15:0];
            end
            case (state)
                S_IDLE: begin
                    if (wr_access && paddr == `REG_CMD_OFS && !busy && pwdata[2:0] != `CMD_NONE) begin
                        cmd       <= pwdata[2:0];
                        busy      <= 1'b1;
                        done_flag <= 1'b0;
                        timeout   <= 1'b0;
                        aborted   <= 1'b0;
                        cyc_start <= 1'b1;
                        cyc_write <= (pwdata[2:0] == `CMD_WRITE);
                        // Status is always polled at the software-given address
                        cyc_addr  <= addr;
                        cyc_wdata <= wdata;
                        state     <= (pwdata[2:0] == `CMD_WRITE || pwdata[2:0] == `CMD_READ)
                                     ? S_CYCLE : S_FIRST;
                    end
                end
                S_CYCLE: begin
                    if (cyc_done) begin
                        rdata_hold <= cyc_rdata;
                        busy       <= 1'b0;
                        done_flag  <= 1'b1;
                        state      <= S_IDLE;
                    end
                end
                S_FIRST: begin
                    // First of two back-to-back status reads
                    if (cyc_done) begin
                        prev      <= cyc_rdata;
                        cyc_start <= 1'b1;
                        state     <= S_SECOND;
                    end
                end
                S_SECOND: begin
                    if (cyc_done) begin
                        rdata_hold <= cyc_rdata;
                        // Erase timer read only after toggling shows acceptance
                        erase_started  <= cyc_rdata[`BIT_ERASE_TIMER] && toggling;
                        sector_erasing <= cyc_rdata[`BIT_SECOND_TOGGLE] != prev[`BIT_SECOND_TOGGLE];
                        if (!toggling) begin
                            busy      <= 1'b0;
                            done_flag <= 1'b1;
                            state     <= S_IDLE;
                        end else if (cmd == `CMD_POLL_ERASE) begin
                            // Single snapshot of erase window; software re-issues
                            busy      <= 1'b0;
                            done_flag <= 1'b1;
                            state     <= S_IDLE;
                        end else if (cyc_rdata[`BIT_TIMEOUT_ERROR] || cyc_rdata[`BIT_BUFFER_ABORT]) begin
                            // Toggle may stop as the flag rises; look once more
                            prev          <= cyc_rdata;
                            rechk_timeout <= cyc_rdata[`BIT_TIMEOUT_ERROR];
                            cyc_start     <= 1'b1;
                            state         <= S_RECHK;
                        end else begin
                            prev      <= cyc_rdata;
                            cyc_start <= 1'b1;
                        end
                    end
                end
                S_RECHK: begin
                    if (cyc_done) begin
                        rdata_hold <= cyc_rdata;
                        if (!toggling) begin
                            busy      <= 1'b0;
                            done_flag <= 1'b1;
                            state     <= S_IDLE;
                        end else begin
                            // Failed: write the recovery command
                            timeout   <= rechk_timeout;
                            aborted   <= !rechk_timeout;
                            cyc_start <= 1'b1;
                            cyc_write <= 1'b1;
                            cyc_wdata <= 16'h00F0;
                            state     <= S_RESET;
                        end
                    end
                end
                S_RESET: begin
                    // Only a plain reset is issued; abort-reset unlock cycles are left to software
                    if (cyc_done) begin
                        busy      <= 1'b0;
                        done_flag <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Single bus cycle engine
    flash_bus_cycle u_cycle (
        .clock        (clock),
        .rst          (rst),
        .start        (cyc_start),
        .write        (cyc_write),
        .addr         (cyc_addr),
        .wdata        (cyc_wdata),
        .done         (cyc_done),
        .rdata        (cyc_rdata),
        .flash_addr   (flash_addr),
        .flash_ce_n   (flash_ce_n),
        .flash_oe_n   (flash_oe_n),
        .flash_we_n   (flash_we_n),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe),
        .flash_dq_in  (flash_dq_in)
    );

endmodule // flash_status_host

//--- sim/flash_status_checker.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the flash status host
module flash_status_checker (
    // Clock, reset, bus
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Flash pins
    input wire logic [22:0] flash_addr,
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic [15:0] flash_dq_out,
    input wire logic        flash_dq_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Strobe phases; read address and write data must not move for 8 cycles after the strobe opens
    sequence s_rd_hold; !flash_oe_n && !flash_ce_n && $stable(flash_addr); endsequence
    sequence s_wr_hold; !flash_we_n && flash_dq_oe && $stable(flash_dq_out); endsequence
    property p_read_strobe; $fell(flash_oe_n) |=> s_rd_hold [*8]; endproperty
    property p_write_strobe; $fell(flash_we_n) |=> s_wr_hold [*8]; endproperty
    property p_cycle_ends; $fell(flash_ce_n) |-> ##[1:40] $rose(flash_ce_n); endproperty
    property p_no_both; !(!flash_oe_n && !flash_we_n); endproperty
    property p_dq_release; flash_dq_oe |-> (!flash_we_n || $past(!flash_we_n)); endproperty
    property p_pready; psel && penable |-> pready; endproperty
    property p_unmapped; psel && penable && paddr > 12'h010 |-> pslverr && prdata == 32'h0; endproperty
    property p_mapped; psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    property p_reset_idle;
        disable iff (1'b0) rst |=> flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe;
    endproperty
    a_read_strobe:  assert property (p_read_strobe) else $error("read strobe cut short");
    a_write_strobe: assert property (p_write_strobe) else $error("write strobe unstable");
    a_cycle_ends:   assert property (p_cycle_ends) else $error("flash cycle never ends");
    a_no_both:      assert property (p_no_both) else $error("read and write strobes together");
    a_dq_release:   assert property (p_dq_release) else $error("data bus driven outside write");
    a_pready:       assert property (p_pready) else $error("bus wait state seen");
    a_unmapped:     assert property (p_unmapped) else $error("unmapped access not refused");
    a_mapped:       assert property (p_mapped) else $error("mapped access refused");
    a_reset_idle:   assert property (p_reset_idle) else $error("pins not idle after reset");
endmodule // flash_status_checker

bind flash_status_host flash_status_checker i_chk (.clock, .rst, .psel, .penable, .paddr, .prdata,
    .pready, .pslverr, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe);

//--- sim/flash_dev_model.sv
`timescale 1ns/1ps
// ==========================================
// Behavioural flash: status bits over a small array
module flash_dev_model (
    // Flash pins
    input  wire logic [22:0] flash_addr,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic [15:0] flash_dq_out,
    output wire logic [15:0] flash_dq_in,
    output wire logic        ready_busy_output,
    // Scenario control
    input  wire logic [2:0]  op,
    input  wire logic        op_go,
    input  wire logic [3:0]  busy_reads
);
    logic [15:0] mem [0:15];
    logic [2:0]  st;   // 0 array, 1 program, 2 window, 3 erasing, 4 overrun, 5 abort
    logic [3:0]  cnt;
    logic        t6;
    logic        t2;
    logic [15:0] last;
    logic [15:0] word;
    wire         rd = !flash_ce_n && !flash_oe_n;
    wire         wr = !flash_ce_n && !flash_we_n;
    wire  [3:0]  a  = flash_addr[3:0];
    initial begin
        st = 0; cnt = 0; t6 = 0; t2 = 0; last = 16'h0000;
        foreach (mem[i]) mem[i] = 16'hFFFF;
    end
    // Scenario start; any state, the window included, is loaded straight from op
    always @(posedge op_go) begin st = op; cnt = busy_reads; end
    // Read word: array when idle, else status bits; follows every array write
    always_comb begin
        word = (st == 3'd0) ? mem[a] :
            {8'h00, (st == 3'd2 || st == 3'd3) ? 1'b0 : ~mem[a][7], t6, st == 3'd4, 1'b0,
             st == 3'd3, (st == 3'd2 || st == 3'd3) ? t2 : 1'b0, st == 3'd5, 1'b0};
    end
    // Released bus shows the inverse of the last word, never a stale copy
    assign flash_dq_in = rd ? word : ~last;
    assign ready_busy_output = (st == 3'd0);
    // Progress and toggles advance once per read cycle
    always @(posedge rd) begin
        if (st == 3'd1 || st == 3'd2 || st == 3'd3) begin
            if (cnt == 4'h0) begin st = (st == 3'd2) ? 3'd3 : 3'd0; cnt = busy_reads; end
            else cnt = cnt - 4'h1;
        end
        if (st != 3'd0) begin t6 = ~t6; t2 = ~t2; end
    end
    always @(negedge rd) last = word;
    // Writes: recovery, programming, added sectors; the rest is ignored
    always @(negedge wr) begin
        if (flash_dq_out == 16'h00F0 && (st == 3'd4 || st == 3'd5)) st = 3'd0;
        else if (st == 3'd0) mem[a] = mem[a] & flash_dq_out;
        else if (st == 3'd2 && flash_dq_out == 16'h0030) cnt = busy_reads;
    end
endmodule // flash_dev_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "flash_status_regs.vh"
// ==========================================
// Bench for the flash status host
module tb_top;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, e;
    logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, rb, op_go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [22:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in;
    logic [2:0]  op;
    logic [3:0]  busy_reads;
    int          fail_count = 0;
    int          cmp_count = 0;
    typedef struct packed {logic [2:0] o; logic [2:0] c; logic [31:0] exp; logic [31:0] mask;} row_t;
    row_t rows [4] = '{'{3'd1, `CMD_POLL, 32'h22, 32'h2E}, '{3'd5, `CMD_POLL, 32'h8, 32'hC},
                       '{3'd2, `CMD_POLL_ERASE, 32'h40, 32'h50}, '{3'd3, `CMD_POLL_ERASE, 32'h50, 32'h50}};

    flash_status_host i_flash_status_host (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out,
        .flash_dq_oe, .flash_dq_in, .ready_busy_output(rb));
    flash_dev_model i_flash_dev_model (.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out,
        .flash_dq_in, .ready_busy_output(rb), .op, .op_go, .busy_reads);

    // Clock
    initial begin clock = 0; forever #4 clock = ~clock; end

    task wrap_up;
        $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        cmp_count++;
        if ((got & mask) !== (exp & mask)) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer; the request is held until pready is seen high
    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= ad; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin fail_count++; wrap_up; end
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Order a flash command and poll until the controller is idle
    task run(input logic [3:0] ad, input logic [15:0] d, input logic [2:0] c);
        int n;
        apb(1, `REG_ADDR_OFS, {28'h0, ad});
        apb(1, `REG_WDATA_OFS, {16'h0, d});
        apb(1, `REG_CMD_OFS, {29'h0, c});
        n = 0;
        do begin apb(0, `REG_STATUS_OFS, 0); n++; end while (q[`ST_BUSY] !== 1'b0 && n < 400);
        if (n >= 400) begin fail_count++; wrap_up; end
    endtask
    task go(input logic [2:0] o, input logic [3:0] b);
        @(posedge clock);
        op <= o; busy_reads <= b; op_go <= 1;
        @(posedge clock);
        op_go <= 0;
    endtask

    // Hang guard
    initial begin repeat (100000) @(posedge clock); fail_count++; wrap_up; end
    // Main sequence
    initial begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; op = 0; op_go = 0; busy_reads = 0;
        repeat (16) @(posedge clock);
        rst <= 0;
        apb(0, `REG_STATUS_OFS, 0);
        // The idle model holds the ready pin high, and status mirrors it
        chk(q, `RESET_VAL_STATUS | (32'h1 << `ST_READY_PIN), 32'hFFFFFFFF);
        apb(0, 12'h014, 0);
        chk({31'h0, e}, 32'h1, 32'h1);
        chk(q, 32'h0, 32'hFFFFFFFF);
        foreach (rows[i]) begin
            go(rows[i].o, (rows[i].o == 3'd1) ? 4'd5 : 4'd8);
            run(4'h0, 16'h0000, rows[i].c);
            chk(q, rows[i].exp, rows[i].mask);
        end
        // Programming only clears bits
        go(0, 0);
        run(4'h3, 16'h00FF, `CMD_WRITE);
        run(4'h3, 16'hFF0F, `CMD_WRITE);
        run(4'h3, 16'h0000, `CMD_READ);
        apb(0, `REG_RDATA_OFS, 0);
        chk(q, 32'h000F, 32'hFFFF);
        // Overrun, recovery write, then array reads again
        go(4, 0);
        run(4'h3, 16'h0000, `CMD_POLL);
        chk(q, 32'h4, 32'h4);
        run(4'h3, 16'h0000, `CMD_READ);
        apb(0, `REG_RDATA_OFS, 0);
        chk(q, 32'h000F, 32'hFFFF);
        // An added sector erase restarts the acceptance window
        go(2, 2);
        run(4'h0, 16'h0000, `CMD_POLL_ERASE);
        run(4'h0, 16'h0030, `CMD_WRITE);
        run(4'h0, 16'h0000, `CMD_POLL_ERASE);
        chk(q, 32'h40, 32'h50);
        // Reset in the middle of a status read: pins go idle, status clears
        go(4, 0);
        apb(1, `REG_CMD_OFS, {29'h0, `CMD_POLL});
        repeat (10) @(posedge clock);
        rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        apb(0, `REG_STATUS_OFS, 0);
        chk(q, `RESET_VAL_STATUS, 32'hFFFFFFFF);
        wrap_up;
    end
endmodule // tb_top
